// >>> hw/sbi_core.sv
// Serial bus interface: I2C master/slave; serial port mode drives its pins but cannot start a transfer
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "sbi_cfg.svh"
module sbi_core (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   input  wire logic        ce,
   // APB
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // Pins (I2C: sda, scl; serial: sck, so, si)
   input  wire logic        sdaIn,
   input  wire logic        sclIn,
   output sbi_pkg::sbi_pins_t pins,
   output logic             sckOut,
   output logic             sckOe,
   // Status
   output logic             busIrq,
   output logic             idle2Run
);
   logic [5:0] wrSel;
   logic [5:0] rdSel;
   logic [7:0] wd;
   logic [47:0] rdBus;
   sbi_apb uApb (
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .wrSel(wrSel), .rdSel(rdSel), .wrData(wd), .rdBus(rdBus)
   );
   logic sda;
   logic scl;
   sbi_sync uSda (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .din(sdaIn), .dout(sda));
   sbi_sync uScl (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .din(sclIn), .dout(scl));

   typedef enum logic [5:0] {
      S_IDLE  = 6'b000001,
      S_START = 6'b000010,
      S_LOW   = 6'b000100,
      S_HIGH  = 6'b001000,
      S_HOLD  = 6'b010000,
      S_STOP  = 6'b100000
   } st_t;
   st_t st_r;

   logic [7:0] ctrl1_r;
   logic [7:0] own_r;
   logic [7:0] baud0_r;
   logic [7:0] baud1_r;
   logic [1:0] swrst_r;
   logic       swPend_r;
   sbi_pkg::sbi_mode_t mode_r;
   sbi_pkg::sbi_status_t stat_r;
   logic [7:0] txBuf_r;
   logic [7:0] rxBuf_r;
   logic [3:0] bitNo_r;
   logic [15:0] cnt_r;
   logic       sdaDrv_r;
   logic       addrPhase_r;
   logic       sdaD_r;
   logic       sclD_r;
   logic       softRst;
   logic       irqEv;
   logic       bufAcc;
   logic       startDet;
   logic       stopDet;
   logic       sclRise;
   logic       sclFall;
   logic       isMaster;
   logic       txBit;

   assign sclRise  = scl & ~sclD_r;
   assign sclFall  = ~scl & sclD_r;
   assign startDet = scl & sclD_r & sdaD_r & ~sda;
   assign stopDet  = scl & sclD_r & ~sdaD_r & sda;
   assign bufAcc   = wrSel[1] | rdSel[1];
   assign isMaster = stat_r.master;
   assign txBit    = (bitNo_r == 4'h8) ? 1'b1 : txBuf_r[7 - bitNo_r[2:0]];
   // Reads of the shared offset see status
   assign rdBus = {baud1_r, baud0_r, 8'(stat_r), 8'h00, rxBuf_r, ctrl1_r};

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sdaD_r <= 1'b1;
         sclD_r <= 1'b1;
      end else if (ce) begin
         sdaD_r <= sda;
         sclD_r <= scl;
      end
   end

   // Reset code sequence, second code must follow first
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         swrst_r  <= 2'h0;
         swPend_r <= 1'b0;
      end else if (ce && wrSel[3]) begin
         swrst_r  <= wd[1:0];
         swPend_r <= (swrst_r == `SBI_SWRST_FIRST) && (wd[1:0] == `SBI_SWRST_SECOND);
      end else if (ce) begin
         swPend_r <= 1'b0;
      end
   end
   assign softRst = swPend_r;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctrl1_r <= `SBI_CTRL1_RST;
         own_r   <= 8'h00;
         baud0_r <= 8'h00;
         baud1_r <= 8'h00;
         mode_r  <= sbi_pkg::SBI_PORT;
      end else if (ce) begin
         ctrl1_r[`SBI_BIT_SOFT_RESET_MONITOR] <= ~softRst;
         if (wrSel[0]) ctrl1_r[7:1] <= wd[7:1];
         if (wrSel[2]) own_r <= wd;
         if (wrSel[4]) baud0_r <= {1'b0, wd[`SBI_BIT_IDLE2RUN], 6'h00};
         if (wrSel[5]) baud1_r <= {wd[`SBI_BIT_BAUDEN], 7'h00};
         if (wrSel[3]) mode_r <= sbi_pkg::sbi_mode_t'(wd[3:2]);
      end
   end
   assign idle2Run = baud0_r[`SBI_BIT_IDLE2RUN];

   // Protocol engine; bit timing fixed at standard speed
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_r        <= S_IDLE;
         stat_r      <= sbi_pkg::sbi_status_t'(`SBI_STATUS_RST);
         txBuf_r     <= 8'h00;
         rxBuf_r     <= 8'h00;
         bitNo_r     <= 4'h0;
         cnt_r       <= 16'h0;
         sdaDrv_r    <= 1'b1;
         addrPhase_r <= 1'b0;
      end else if (ce) begin
         if (softRst) begin
            st_r   <= S_IDLE;
            stat_r <= sbi_pkg::sbi_status_t'(`SBI_STATUS_RST);
            sdaDrv_r <= 1'b1;
         end else begin
            if (wrSel[1]) txBuf_r <= wd;
            if (bufAcc) stat_r.notPending <= 1'b1;
            if (wrSel[3] && wd[`SBI_BIT_PIN]) stat_r.notPending <= 1'b1;
            if (startDet) stat_r.busBusy <= 1'b1;
            if (stopDet) begin
               stat_r.busBusy  <= 1'b0;
               stat_r.master   <= 1'b0;
               stat_r.transmit <= 1'b0;
               addrPhase_r     <= 1'b0;
               st_r <= S_IDLE;
            end
            if (startDet && !isMaster) begin
               addrPhase_r <= 1'b1;
               bitNo_r     <= 4'h0;
               stat_r.addressed <= 1'b0;
               stat_r.genCall   <= 1'b0;
            end
            unique case (st_r)
               S_IDLE: begin
                  if (wrSel[3] && mode_r == sbi_pkg::SBI_I2C && wd[7:4] == 4'hf
                      && !stat_r.busBusy) begin
                     stat_r.master   <= 1'b1;
                     stat_r.transmit <= 1'b1;
                     stat_r.arbLost  <= 1'b0;
                     cnt_r    <= 16'(`SBI_HALF_CYC);
                     st_r     <= S_START;
                     sdaDrv_r <= 1'b1;
                  end
               end
               S_START: begin
                  // Data falls a half bit before the clock, or no start is seen
                  if (cnt_r != 16'h0) cnt_r <= cnt_r - 16'h1;
                  else if (sdaDrv_r) begin
                     sdaDrv_r <= 1'b0;
                     cnt_r    <= 16'(`SBI_HALF_CYC);
                  end else begin
                     bitNo_r     <= 4'h0;
                     addrPhase_r <= 1'b1;
                     cnt_r <= 16'(`SBI_HALF_CYC);
                     st_r  <= S_LOW;
                  end
               end
               S_LOW: begin
                  // Data moves mid-low so it never changes with the clock high
                  if (baud1_r[`SBI_BIT_BAUDEN] && cnt_r != 16'h0) begin
                     cnt_r <= cnt_r - 16'h1;
                     if (cnt_r == 16'(`SBI_HALF_CYC / 2)) sdaDrv_r <= txBit;
                  end else if (baud1_r[`SBI_BIT_BAUDEN]) begin
                     cnt_r <= 16'(`SBI_HALF_CYC);
                     st_r  <= S_HIGH;
                  end
               end
               S_HIGH: begin
                  if (scl && cnt_r != 16'h0) cnt_r <= cnt_r - 16'h1;
                  else if (scl) begin
                     if (sdaDrv_r && !sda && bitNo_r != 4'h8) begin
                        stat_r.arbLost <= 1'b1;
                        stat_r.master  <= 1'b0;
                        stat_r.transmit <= 1'b0;
                        sdaDrv_r <= 1'b1;
                        st_r <= S_IDLE;
                     end else begin
                        stat_r.lastBit <= sda;
                        rxBuf_r  <= {rxBuf_r[6:0], sda};
                        cnt_r    <= 16'(`SBI_HALF_CYC);
                        if (bitNo_r == 4'h8) begin
                           stat_r.notPending <= 1'b0;
                           txBuf_r <= 8'h00;
                           if (addrPhase_r && !sda) stat_r.transmit <= ~txBuf_r[0];
                           addrPhase_r <= 1'b0;
                           bitNo_r <= 4'h0;
                           st_r <= S_HOLD;
                        end else begin
                           bitNo_r <= bitNo_r + 4'h1;
                           st_r <= S_LOW;
                        end
                     end
                  end
               end
               S_HOLD: begin
                  // SCL stays low until software services the byte; the access itself resumes
                  if (wrSel[3] && wd[`SBI_BIT_PIN] && !wd[`SBI_BIT_BB]) begin
                     sdaDrv_r <= 1'b0;
                     cnt_r    <= 16'(`SBI_HALF_CYC);
                     st_r     <= S_STOP;
                  end else if (bufAcc || (wrSel[3] && wd[`SBI_BIT_PIN])) begin
                     cnt_r <= 16'(`SBI_HALF_CYC);
                     st_r  <= S_LOW;
                  end
               end
               S_STOP: begin
                  if (cnt_r != 16'h0) cnt_r <= cnt_r - 16'h1;
                  else begin
                     sdaDrv_r <= 1'b1;
                     st_r <= S_IDLE;
                  end
               end
               default: st_r <= S_IDLE;
            endcase
            // Slave receive path
            if (!isMaster && addrPhase_r && sclRise && !startDet) begin
               rxBuf_r <= {rxBuf_r[6:0], sda};
               stat_r.lastBit <= sda;
               bitNo_r <= bitNo_r + 4'h1;
               if (bitNo_r == 4'h7) begin
                  if (rxBuf_r[6:0] == `SBI_GENCALL && !sda) begin
                     stat_r.genCall   <= 1'b1;
                     stat_r.addressed <= 1'b1;
                  end else if (!own_r[0] && rxBuf_r[6:0] == own_r[7:1]) begin
                     stat_r.addressed <= 1'b1;
                     stat_r.transmit  <= sda;
                  end
               end
            end
            // Stretch only after the clock falls, never inside a high phase
            if (!isMaster && addrPhase_r && sclFall && bitNo_r == 4'h8) begin
               addrPhase_r <= 1'b0;
               if (stat_r.addressed) begin
                  stat_r.notPending <= 1'b0;
                  txBuf_r <= 8'h00;
               end
            end
         end
      end
   end

   assign busIrq = ~stat_r.notPending;
   // Port mode disables outputs; serial mode uses clock, data out pins
   always_comb begin
      pins = '{sclOut: 1'b0, sclOe: 1'b0, sdaOut: 1'b0, sdaOe: 1'b0};
      sckOut = 1'b1;
      sckOe  = 1'b0;
      if (mode_r == sbi_pkg::SBI_I2C) begin
         pins.sclOe = (st_r == S_LOW) || (st_r == S_HOLD) || !stat_r.notPending
                      || (st_r == S_STOP && cnt_r > 16'(`SBI_HALF_CYC / 2));
         pins.sdaOe = ~sdaDrv_r;
      end else if (mode_r == sbi_pkg::SBI_SIO) begin
         sckOe = 1'b1;
         sckOut = (st_r != S_LOW);
         pins.sdaOe = 1'b1;
         pins.sdaOut = sdaDrv_r;
      end
   end
endmodule // sbi_core
`default_nettype wire

// >>> hw/sbi_cfg.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SBI_CFG_SVH
`define SBI_CFG_SVH
`define SBI_OFS_CTRL1     12'h240
`define SBI_OFS_DATA      12'h241
`define SBI_OFS_OWNADDR   12'h242
`define SBI_OFS_CTRL2     12'h243
`define SBI_OFS_BAUD0     12'h244
`define SBI_OFS_BAUD1     12'h245
`define SBI_ADDR_BYTE(i)  ((i) * 4)
`define SBI_STATUS_RST    8'h10
`define SBI_CTRL1_RST     8'h01
`define SBI_BIT_MST       7
`define SBI_BIT_TRX       6
`define SBI_BIT_BB        5
`define SBI_BIT_PIN       4
`define SBI_BIT_CLOCK_RATE_SELECT_LOW      4
`define SBI_BIT_SOFT_RESET_MONITOR    0
`define SBI_BIT_IDLE2RUN  6
`define SBI_BIT_BAUDEN    7
`define SBI_SWRST_FIRST   2'h2
`define SBI_SWRST_SECOND  2'h1
`define SBI_MODE_PORT     2'h0
`define SBI_MODE_SIO      2'h1
`define SBI_MODE_I2C      2'h2
`define SBI_GENCALL       7'h00
`define SBI_CLK_MHZ       100
`define SBI_SCL_KHZ       100
`define SBI_HALF_CYC      ((`SBI_CLK_MHZ * 1000) / (`SBI_SCL_KHZ * 2))
`endif

// >>> hw/sbi_pkg.sv
// Types shared by the serial bus interface
package sbi_pkg;
   typedef enum logic [1:0] {
      SBI_PORT = 2'h0,
      SBI_SIO  = 2'h1,
      SBI_I2C  = 2'h2,
      SBI_RSVD = 2'h3
   } sbi_mode_t;
   typedef struct packed {
      logic master;
      logic transmit;
      logic busBusy;
      logic notPending;
      logic arbLost;
      logic addressed;
      logic genCall;
      logic lastBit;
   } sbi_status_t;
   typedef struct packed {
      logic sclOut;
      logic sclOe;
      logic sdaOut;
      logic sdaOe;
   } sbi_pins_t;
endpackage

// >>> hw/sbi_sync.sv
// Two-flop synchroniser for one pin
`timescale 1ns/1ps
`default_nettype none
module sbi_sync (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic arst_n,
   input  wire logic ce,
   // Data
   input  wire logic din,
   output var  logic dout
);
   logic meta_r;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         meta_r <= 1'b1;
         dout   <= 1'b1;
      end else if (ce) begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule // sbi_sync
`default_nettype wire

// >>> hw/sbi_apb.sv
// APB slave front end: decodes byte-wide registers into strobes
`timescale 1ns/1ps
`default_nettype none
`include "sbi_cfg.svh"
module sbi_apb (
   // APB
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // Register side
   output logic [5:0]       wrSel,
   output logic [5:0]       rdSel,
   output logic [7:0]       wrData,
   input  wire logic [47:0] rdBus
);
   logic acc;
   logic hit;
   assign acc = psel & penable;
   assign pready = 1'b1;
   assign wrData = pwdata[7:0];
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : gSel
         localparam logic [11:0] A = 12'(`SBI_ADDR_BYTE(`SBI_OFS_CTRL1 + g));
         assign wrSel[g] = acc & pwrite & (paddr == A);
         assign rdSel[g] = acc & ~pwrite & (paddr == A);
      end
   endgenerate
   assign hit = |{wrSel, rdSel};
   assign pslverr = acc & ~hit;
   always_comb begin
      prdata = 32'h0;
      for (int i = 0; i < 6; i++) begin
         if (rdSel[i]) prdata[7:0] = rdBus[i*8 +: 8];
      end
   end
endmodule // sbi_apb
`default_nettype wire

// >>> test/sbi_core_assertions.sv
// Concurrent checks on the serial bus interface ports
`timescale 1ns/1ps
`default_nettype none
module sbi_core_assertions (
   // Clock and reset
   input wire logic               clk_sys,
   input wire logic               arst_n,
   // APB
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [11:0]        paddr,
   input wire logic [31:0]        pwdata,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic [31:0]        prdata,
   // Pins and status
   input wire sbi_pkg::sbi_pins_t pins,
   input wire logic               busIrq,
   input wire logic               idle2Run
);
   logic acc;
   logic mapped;
   logic dataAcc;
   assign acc = psel && penable;
   assign mapped = paddr inside {12'h900, 12'h904, 12'h908, 12'h90c, 12'h910, 12'h914};
   assign dataAcc = acc && (paddr == 12'h904);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   a_ready_in_access: assert property (acc |-> pready)
      else $error("pready low in access phase");
   a_read_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   a_unmapped_error: assert property (acc && !mapped |-> pslverr)
      else $error("no error on unmapped address");
   a_mapped_no_error: assert property (acc && mapped |-> !pslverr)
      else $error("error on mapped address");
   a_pending_mirror: assert property (acc && !pwrite && paddr == 12'h90c |-> prdata[4] == !busIrq)
      else $error("pending bit disagrees with interrupt");
   a_irq_holds_scl: assert property ($rose(busIrq) |-> ##[0:2] pins.sclOe)
      else $error("clock not held low on interrupt");
   a_data_access_clears: assert property (dataAcc && busIrq |-> ##[1:2] !busIrq)
      else $error("buffer access left interrupt pending");
   a_idle2_update: assert property (acc && pwrite && paddr == 12'h910 |=> idle2Run == $past(pwdata[6]))
      else $error("idle2 run bit not written");
   a_reset_released: assert property ($rose(arst_n) |-> !pins.sclOe && !pins.sdaOe)
      else $error("pins driven after reset");
   c_irq: cover property ($rose(busIrq));
   c_slverr: cover property (acc && pslverr);
   c_idle2: cover property ($rose(idle2Run));
endmodule // sbi_core_assertions
bind sbi_core sbi_core_assertions u_sbi_core_assertions (
   .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .pins(pins), .busIrq(busIrq), .idle2Run(idle2Run));
`default_nettype wire

// >>> test/sbi_i2c_peer.sv
// Open-drain bus with pull-ups and an I2C peer that acks or sends an address
`timescale 1ns/1ps
`default_nettype none
module sbi_i2c_peer (
   // Device pulls
   input  wire logic  sclOe,
   input  wire logic  sdaOe,
   input  wire logic  sdaOut,
   // Resolved bus
   output logic       sclBus,
   output logic       sdaBus,
   // Byte seen on the bus
   output logic [7:0] rxByte
);
   logic       pScl;
   logic       pSda;
   logic       drv;
   logic       ack;
   logic [3:0] cnt;
   // Released lines float high through the pull-ups; serial mode drives data both ways
   assign sclBus = !sclOe && pScl;
   assign sdaBus = (!sdaOe || sdaOut) && pSda && !ack;
   initial begin
      pScl = 1'b1;
      pSda = 1'b1;
      drv = 1'b0;
      ack = 1'b0;
      cnt = 4'h0;
      rxByte = 8'h00;
   end
   always @(negedge sdaBus) begin
      if (sclBus) begin
         cnt = 4'h0;
      end
   end
   always @(posedge sclBus) begin
      if (cnt < 4'h8) begin
         rxByte = {rxByte[6:0], sdaBus};
      end
      cnt = cnt + 4'h1;
   end
   // Ack only while the device is the sender
   always @(negedge sclBus) begin
      ack = !drv && (cnt == 4'h8);
   end
   // Start, eight bits and a released ack slot at 160 ns per bit
   task automatic sendByte(input logic [7:0] b);
      drv = 1'b1;
      pSda = 1'b0;
      #80;
      pScl = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         pSda = b[i];
         #40;
         pScl = 1'b1;
         #80;
         pScl = 1'b0;
         #40;
      end
      pSda = 1'b1;
      #40;
      pScl = 1'b1;
      #80;
      pScl = 1'b0;
      drv = 1'b0;
   endtask
   task automatic stop();
      pSda = 1'b0;
      #80;
      pScl = 1'b1;
      #80;
      pSda = 1'b1;
      #80;
   endtask
endmodule // sbi_i2c_peer
`default_nettype wire

// >>> test/sbi_core_tb.sv
// Self-checking bench for the serial bus interface
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
   $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module sbi_core_tb;
   logic               clk_sys;
   logic               arst_n;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [11:0]        paddr;
   logic [31:0]        pwdata;
   logic               pready;
   logic               pslverr;
   logic [31:0]        prdata;
   sbi_pkg::sbi_pins_t pins;
   logic               sclBus;
   logic               sdaBus;
   logic               busIrq;
   logic               idle2Run;
   logic [7:0]         rxByte;
   logic [31:0]        rd;
   logic               err;
   int                 fails;
   int                 n_tests;
   logic [7:0]         slvAddr [2] = '{8'h00, 8'ha4};
   logic [7:0]         slvStat [2] = '{8'h26, 8'h24};
   always #5 clk_sys = ~clk_sys;
   sbi_core u_sbi_core (.clk_sys(clk_sys), .arst_n(arst_n), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .sdaIn(sdaBus), .sclIn(sclBus), .pins(pins),
      .sckOut(), .sckOe(), .busIrq(busIrq), .idle2Run(idle2Run));
   sbi_i2c_peer u_sbi_i2c_peer (.sclOe(pins.sclOe), .sdaOe(pins.sdaOe),
      .sdaOut(pins.sdaOut), .sclBus(sclBus),
      .sdaBus(sdaBus), .rxByte(rxByte));
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
      if (n >= 50 && pready !== 1'b1) begin
         fails++;
         end_sim();
      end
   endtask
   task automatic chk(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      `CHK(rd, {24'h0, e})
   endtask
   task automatic waitIrq();
      int n;
      n = 0;
      while (busIrq !== 1'b1 && n < 40000) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 40000) begin
         fails++;
         end_sim();
      end
   endtask
   // Soft reset keeps the mode, own address and baud registers; I2C setup is still redone each time
   task automatic cfgI2c();
      apb(1'b1, 12'h908, 8'ha4);
      apb(1'b1, 12'h914, 8'h80);
      apb(1'b1, 12'h90c, 8'h08);
   endtask
   task automatic softReset();
      apb(1'b1, 12'h90c, 8'h0a);
      apb(1'b1, 12'h90c, 8'h09);
      u_sbi_i2c_peer.stop();
      @(posedge clk_sys);
      chk(12'h90c, 8'h10);
   endtask
   initial begin
      clk_sys = 1'b0;
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      fails = 0;
      n_tests = 0;
      repeat (10) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      chk(12'h90c, 8'h10);
      chk(12'h900, 8'h01);
      chk(12'h910, 8'h00);
      apb(1'b1, 12'h910, 8'h40);
      chk(12'h910, 8'h40);
      `CHK(idle2Run, 1'b1)
      apb(1'b1, 12'h920, 8'h55);
      `CHK(err, 1'b1)
      apb(1'b1, 12'h900, 8'h00);
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, 12'h90c, 8'(m << 2));
         if (m % 2 == 0) begin
            chk(12'h90c, 8'h10);
         end
      end
      $display("test registers done");
      cfgI2c();
      apb(1'b1, 12'h904, 8'h5a);
      apb(1'b1, 12'h90c, 8'hf8);
      waitIrq();
      `CHK(rxByte, 8'h5a)
      chk(12'h90c, 8'he0);
      `CHK(pins.sclOe, 1'b1)
      apb(1'b0, 12'h904, 8'h00);
      chk(12'h90c, 8'hf0);
      softReset();
      $display("test master done");
      for (int k = 0; k < 2; k++) begin
         cfgI2c();
         u_sbi_i2c_peer.sendByte(slvAddr[k]);
         @(posedge clk_sys);
         waitIrq();
         chk(12'h90c, slvStat[k]);
         chk(12'h904, slvAddr[k]);
         softReset();
      end
      $display("test slave done");
      end_sim();
   end
endmodule // sbi_core_tb
`default_nettype wire
